// ===== include/lp_timing_pkg.sv
`default_nettype none
package lp_timing_pkg;
  localparam int CLK_PERIOD_PS = 100_000;
  localparam int CNT_W = 16;
  localparam int ZQ_INIT_NCK = 1024;
  localparam int ZQ_OPER_NCK = 512;
  localparam int ZQ_SHORT_NCK = 128;
  localparam int CMD_PASS_DIS_NCK = 4;
  localparam int MR_UPD_NCK = 24;
  localparam int MR_UPD_PS = 15_000;
  localparam int CLK_VALID_NCK = 5;
  localparam int CLK_VALID_PS = 10_000;
  localparam int REF_EXTRA_PS = 10_000;
  localparam int RFC_PS_DEF = 350_000;
  localparam int RFC4_PS_DEF = 160_000;
  localparam int XMP_NCK_DEF = 24;
  localparam int DLLK_NCK_DEF = 768;
  localparam int PAR_LAT_DEF = 4;
  function automatic int ps_to_cyc_up(input int ps);
    ps_to_cyc_up = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  endfunction
  function automatic int max2(input int a, input int b);
    max2 = (a > b) ? a : b;
  endfunction
  localparam int MR_UPD_CYC = max2(MR_UPD_NCK, ps_to_cyc_up(MR_UPD_PS));
  localparam int CLK_VALID_CYC =
    max2(CLK_VALID_NCK, ps_to_cyc_up(CLK_VALID_PS));
  localparam int MPSM_ENTRY_CYC = MR_UPD_CYC + CMD_PASS_DIS_NCK;
  typedef enum logic [3:0] {
    CMD_NONE = 4'h0,
    CMD_ZQ_LONG = 4'h1,
    CMD_ZQ_SHORT = 4'h2,
    CMD_MPSM_ENTER = 4'h3,
    CMD_MPSM_EXIT = 4'h4,
    CMD_SR_ENTER = 4'h5,
    CMD_SR_EXIT = 4'h6,
    CMD_PD_ENTER = 4'h7,
    CMD_PD_EXIT = 4'h8,
    CMD_MRS_FAST = 4'h9,
    CMD_NODLL = 4'ha,
    CMD_DLL = 4'hb
  } cmd_t;
endpackage
`default_nettype wire

// ===== hw/lp_down_counter.sv
`default_nettype none
module lp_down_counter #(
  parameter int W = 16
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [W-1:0] load_value,
  output logic busy
);
  logic [W-1:0] count;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else if (load && load_value > count) begin
      count <= load_value;
    end else if (count != '0) begin
      count <= count - 1'b1;
    end
  end
  assign busy = (count != '0);
endmodule
`default_nettype wire

// ===== hw/lp_cmd_gate.sv
`default_nettype none
// Functional notes
// - After a long calibration during the init phase, nothing else issues for 1024 cycles.
// - A long calibration in operation blocks commands for 512 cycles.
// - A short calibration in operation blocks commands for 128 cycles.
// - The clock stays valid for the update delay plus pass-disable delay after power-saving entry.
// - The clock is valid for the self-refresh-exit clock time before power-saving exit.
// - Locked-loop commands wait exit delay plus lock delay after power-saving exit.
// - Commands not needing the locked loop wait refresh cycle plus 10 ns after self-refresh exit.
// - After an aborted self-refresh those commands wait the fine refresh cycle plus 10 ns.
// - Calibration and fast mode writes wait the fine refresh cycle plus 10 ns after self-refresh exit.
// - Locked-loop commands wait the loop lock time after self-refresh exit.
// - The clock stays valid max(5 cycles, 10 ns) after self-refresh or power-down entry.
// - With parity on, that clock hold grows by the parity latency.
// - The mode update delay is max(24 cycles, 15 ns).
// - The clock time before self-refresh exit is max(5 cycles, 10 ns).
module lp_cmd_gate #(
  parameter int RFC_PS = lp_timing_pkg::RFC_PS_DEF,
  parameter int RFC4_PS = lp_timing_pkg::RFC4_PS_DEF,
  parameter int XMP_NCK = lp_timing_pkg::XMP_NCK_DEF,
  parameter int DLLK_NCK = lp_timing_pkg::DLLK_NCK_DEF,
  parameter int PAR_LAT = lp_timing_pkg::PAR_LAT_DEF
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [3:0] req_cmd,
  input wire logic req_valid,
  input wire logic sr_abort,
  input wire logic parity_en,
  input wire logic init_phase,
  output logic req_ready,
  output logic [3:0] ddr_cmd,
  output logic ddr_cmd_valid,
  output logic ck_enable,
  output logic dev_cmd_path_off
);
  localparam int W = lp_timing_pkg::CNT_W;
  localparam int XS_CYC =
    lp_timing_pkg::ps_to_cyc_up(RFC_PS + lp_timing_pkg::REF_EXTRA_PS);
  localparam int XS4_CYC =
    lp_timing_pkg::ps_to_cyc_up(RFC4_PS + lp_timing_pkg::REF_EXTRA_PS);
  localparam int XMPDLL_CYC = XMP_NCK + DLLK_NCK;
  // Every timed count has to fit the shared counter width.
  if (XS_CYC >= (1 << W)) begin
    $error("lp_cmd_gate: self-refresh exit count too wide");
  end
  if (XS4_CYC >= (1 << W)) begin
    $error("lp_cmd_gate: fine refresh exit count too wide");
  end
  if (XMPDLL_CYC >= (1 << W)) begin
    $error("lp_cmd_gate: locked-loop exit count too wide");
  end
  if (lp_timing_pkg::ZQ_INIT_NCK >= (1 << W)) begin
    $error("lp_cmd_gate: calibration count too wide");
  end
  if (PAR_LAT < 0 || PAR_LAT > 255) begin
    $error("lp_cmd_gate: parity latency out of range");
  end
  if (XMP_NCK < 0 || DLLK_NCK < 0) begin
    $error("lp_cmd_gate: exit delays must not be negative");
  end
  if (RFC_PS < 0 || RFC4_PS < 0) begin
    $error("lp_cmd_gate: refresh cycle times must not be negative");
  end

  typedef enum logic [3:0] {
    ST_ACTIVE = 4'b0001,
    ST_CKHOLD = 4'b0010,
    ST_LOWPWR = 4'b0100,
    ST_CKPRE = 4'b1000
  } state_t;

  // Reset is released through two flops; only the second one is read.
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  state_t state;
  state_t next_state;
  logic in_mpsm;
  logic next_in_mpsm;
  logic [3:0] pend_exit;
  logic [3:0] next_pend_exit;

  wire logic is_zql = req_cmd == lp_timing_pkg::CMD_ZQ_LONG;
  wire logic is_zqs = req_cmd == lp_timing_pkg::CMD_ZQ_SHORT;
  wire logic is_mpe = req_cmd == lp_timing_pkg::CMD_MPSM_ENTER;
  wire logic is_mpx = req_cmd == lp_timing_pkg::CMD_MPSM_EXIT;
  wire logic is_sre = req_cmd == lp_timing_pkg::CMD_SR_ENTER;
  wire logic is_srx = req_cmd == lp_timing_pkg::CMD_SR_EXIT;
  wire logic is_pde = req_cmd == lp_timing_pkg::CMD_PD_ENTER;
  wire logic is_pdx = req_cmd == lp_timing_pkg::CMD_PD_EXIT;
  wire logic is_fast = is_zql || is_zqs
    || req_cmd == lp_timing_pkg::CMD_MRS_FAST;
  wire logic is_dll = req_cmd == lp_timing_pkg::CMD_DLL;
  wire logic is_exit = is_mpx || is_srx || is_pdx;
  wire logic is_entry = is_mpe || is_sre || is_pde;

  wire logic zq_busy;
  wire logic ckhold_busy;
  wire logic ckpre_busy;
  wire logic nodll_busy;
  wire logic fast_busy;
  wire logic dll_busy;
  wire logic cpd_busy;

  wire logic fire = req_valid && req_ready;
  wire logic exit_fire = state == ST_CKPRE && !ckpre_busy;

  // Each constraint class runs on its own counter.
  wire logic [W-1:0] zq_len = is_zql
    ? (init_phase ? W'(lp_timing_pkg::ZQ_INIT_NCK)
                  : W'(lp_timing_pkg::ZQ_OPER_NCK))
    : W'(lp_timing_pkg::ZQ_SHORT_NCK);
  wire logic [W-1:0] ckhold_len = is_mpe
    ? W'(lp_timing_pkg::MPSM_ENTRY_CYC)
    : W'(lp_timing_pkg::CLK_VALID_CYC + (parity_en ? PAR_LAT : 0));
  wire logic [W-1:0] nodll_len = in_mpsm ? W'(XMP_NCK)
    : (sr_abort ? W'(XS4_CYC) : W'(XS_CYC));
  wire logic [W-1:0] dll_len = in_mpsm ? W'(XMPDLL_CYC)
    : W'(DLLK_NCK);
  wire logic srx_like = exit_fire && !pend_exit[3];

  // Load strobes and lengths for the counters below.
  wire logic zq_load = fire && (is_zql || is_zqs);
  wire logic entry_load = fire && is_entry;
  wire logic exit_load = fire && is_exit;
  wire logic mpe_load = fire && is_mpe;
  wire logic fast_load = srx_like && !in_mpsm;
  wire logic [W-1:0] ckpre_len =
    W'(lp_timing_pkg::CLK_VALID_CYC);
  wire logic [W-1:0] fast_len = W'(XS4_CYC);
  wire logic [W-1:0] cpd_len =
    W'(lp_timing_pkg::MPSM_ENTRY_CYC);

  lp_down_counter #(
    .W(W)
  ) u_zq (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .load(zq_load),
    .load_value(zq_len),
    .busy(zq_busy)
  );

  lp_down_counter #(
    .W(W)
  ) u_ckhold (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .load(entry_load),
    .load_value(ckhold_len),
    .busy(ckhold_busy)
  );

  lp_down_counter #(
    .W(W)
  ) u_ckpre (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .load(exit_load),
    .load_value(ckpre_len),
    .busy(ckpre_busy)
  );

  lp_down_counter #(
    .W(W)
  ) u_nodll (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .load(srx_like),
    .load_value(nodll_len),
    .busy(nodll_busy)
  );

  lp_down_counter #(
    .W(W)
  ) u_fast (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .load(fast_load),
    .load_value(fast_len),
    .busy(fast_busy)
  );

  lp_down_counter #(
    .W(W)
  ) u_dll (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .load(srx_like),
    .load_value(dll_len),
    .busy(dll_busy)
  );

  lp_down_counter #(
    .W(W)
  ) u_cpd (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .load(mpe_load),
    .load_value(cpd_len),
    .busy(cpd_busy)
  );

  // A command passes only when every counter that governs its class is idle.
  wire logic gate_fast = nodll_busy && !(is_fast && !fast_busy);
  wire logic gate_nodll = zq_busy || gate_fast;
  wire logic active_ok = state == ST_ACTIVE && req_cmd != '0
    && !is_exit && !gate_nodll && !(is_dll && dll_busy);
  // In low power only the exit that matches the pending entry is taken.
  wire logic lowpwr_ok = state == ST_LOWPWR && is_exit
    && req_cmd == pend_exit;
  assign req_ready = active_ok || lowpwr_ok;

  // Entry holds the clock, low power waits for its exit, exit re-arms.
  always_comb begin
    next_state = state;
    next_in_mpsm = in_mpsm;
    next_pend_exit = pend_exit;
    unique case (state)
      ST_ACTIVE: begin
        if (fire && is_entry) begin
          next_state = ST_CKHOLD;
          next_in_mpsm = is_mpe;
          next_pend_exit = is_mpe ? 4'(lp_timing_pkg::CMD_MPSM_EXIT)
            : is_sre ? 4'(lp_timing_pkg::CMD_SR_EXIT)
            : 4'(lp_timing_pkg::CMD_PD_EXIT);
        end
      end
      ST_CKHOLD: begin
        if (!ckhold_busy) begin
          next_state = ST_LOWPWR;
        end
      end
      ST_LOWPWR: begin
        if (fire) begin
          next_state = ST_CKPRE;
        end
      end
      ST_CKPRE: begin
        if (!ckpre_busy) begin
          next_state = ST_ACTIVE;
        end
      end
      default: begin
        next_state = ST_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_ACTIVE;
      in_mpsm <= 1'b0;
      pend_exit <= 4'h0;
    end else begin
      state <= exit_fire ? ST_ACTIVE : next_state;
      in_mpsm <= next_in_mpsm;
      pend_exit <= next_pend_exit;
    end
  end

  // The entry command goes out at once; an exit goes out after the clock
  // has been valid for the required time.
  wire logic next_ddr_cmd_valid = (fire && !is_exit) || exit_fire;
  wire logic [3:0] next_ddr_cmd = exit_fire ? pend_exit
    : (fire ? req_cmd : 4'h0);
  wire logic next_ck_enable = next_state != ST_LOWPWR;
  wire logic next_path_off = in_mpsm && state != ST_ACTIVE && !cpd_busy;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ddr_cmd <= 4'h0;
      ddr_cmd_valid <= 1'b0;
    end else begin
      ddr_cmd <= next_ddr_cmd;
      ddr_cmd_valid <= next_ddr_cmd_valid;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ck_enable <= 1'b1;
      dev_cmd_path_off <= 1'b0;
    end else begin
      ck_enable <= next_ck_enable;
      dev_cmd_path_off <= next_path_off;
    end
  end
endmodule
`default_nettype wire

// ===== dv/lp_cmd_gate_asserts.sv
`default_nettype none
module lp_cmd_gate_asserts #(
  parameter int XMP_NCK = 24,
  parameter int DLLK_NCK = 768,
  parameter int PAR_LAT = 4
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic parity_en,
  input wire logic init_phase,
  input wire logic [3:0] ddr_cmd,
  input wire logic ddr_cmd_valid,
  input wire logic ck_enable
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] gap;
  logic [3:0] last;
  logic [1:0] lf;
  logic ip_q;
  logic pe_q;
  // The gate reads these levels on the edge that takes a command, one
  // edge before that command shows on the bus.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      {ip_q, pe_q} <= '0;
    end else begin
      {ip_q, pe_q} <= {init_phase, parity_en};
    end
  end
  wire logic zl = last == lp_timing_pkg::CMD_ZQ_LONG;
  wire logic zs = last == lp_timing_pkg::CMD_ZQ_SHORT;
  wire logic sx = last == lp_timing_pkg::CMD_SR_EXIT;
  wire logic mx = last == lp_timing_pkg::CMD_MPSM_EXIT;
  wire logic me = last == lp_timing_pkg::CMD_MPSM_ENTER;
  wire logic dl = ddr_cmd == lp_timing_pkg::CMD_DLL;
  wire logic hd = last inside {lp_timing_pkg::CMD_SR_ENTER,
    lp_timing_pkg::CMD_PD_ENTER};
  wire logic ex = ddr_cmd inside {lp_timing_pkg::CMD_SR_EXIT,
    lp_timing_pkg::CMD_MPSM_EXIT};
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      {gap, last, lf} <= '0;
    end else if (ddr_cmd_valid) begin
      {gap, last, lf} <= {16'h0001, ddr_cmd, ip_q, pe_q};
    end else if (gap != 16'hffff) begin
      gap <= gap + 16'h0001;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence s_after(logic c); ddr_cmd_valid && c; endsequence
  property p_zq_init; s_after(zl && lf[1]) |-> gap >= 1024; endproperty
  a_zq_init: assert property (p_zq_init) else $error("zq init gap");
  property p_zq_oper; s_after(zl && !lf[1]) |-> gap >= 512; endproperty
  a_zq_oper: assert property (p_zq_oper) else $error("zq oper gap");
  property p_zq_short; s_after(zs) |-> gap >= 128; endproperty
  a_zq_short: assert property (p_zq_short) else $error("zq short");
  property p_xsdll; s_after(sx && dl) |-> gap >= DLLK_NCK; endproperty
  a_xsdll: assert property (p_xsdll) else $error("dll after sr");
  property p_xmp; s_after(mx && dl) |-> gap >= XMP_NCK + DLLK_NCK; endproperty
  a_xmp: assert property (p_xmp) else $error("dll after mpsm");
  property p_hold; hd && gap < 5 + (lf[0] ? PAR_LAT : 0) |-> ck_enable;
  endproperty
  a_hold: assert property (p_hold) else $error("ck hold");
  property p_mp_ck; me && gap < 28 |-> ck_enable; endproperty
  a_mp_ck: assert property (p_mp_ck) else $error("mpsm ck");
  property p_exit_ck; s_after(ex) |-> $past(ck_enable, 4); endproperty
  a_exit_ck: assert property (p_exit_ck) else $error("exit ck");
endmodule
bind lp_cmd_gate lp_cmd_gate_asserts #(.XMP_NCK(XMP_NCK),
  .DLLK_NCK(DLLK_NCK), .PAR_LAT(PAR_LAT)) u_chk (.core_clk(core_clk),
  .arst_n(arst_n), .parity_en(parity_en), .init_phase(init_phase),
  .ddr_cmd(ddr_cmd), .ddr_cmd_valid(ddr_cmd_valid), .ck_enable(ck_enable));
`default_nettype wire

// ===== dv/lp_dev_model.sv
`default_nettype none
module lp_dev_model #(
  parameter int MPED = 24 + 4
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [3:0] cmd,
  input wire logic cmd_valid,
  input wire logic ck_enable,
  output logic path_off,
  output logic [3:0] bad
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt;
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      {cnt, path_off, bad} <= '0;
    end else if (cmd_valid && cmd == lp_timing_pkg::CMD_MPSM_EXIT) begin
      {cnt, path_off} <= '0;
    end else begin
      if (cmd_valid && (path_off || !ck_enable)) bad <= bad + 4'h1;
      if (cmd_valid && cmd == lp_timing_pkg::CMD_MPSM_ENTER) cnt <= 8'h01;
      else if (cnt != 8'h00 && ck_enable) cnt <= cnt + 8'h01;
      if (cnt >= MPED - 1) path_off <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== dv/tb_lp_cmd_gate.sv
`default_nettype none
module tb_lp_cmd_gate;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DLLK = 16;
  localparam int XS = (lp_timing_pkg::RFC_PS_DEF + 109_999) / 100_000;
  localparam int XS4 = (lp_timing_pkg::RFC4_PS_DEF + 109_999) / 100_000;
  logic core_clk = 0, arst_n = 0, req_valid = 0, sr_abort = 0;
  logic parity_en = 0, init_phase = 1;
  logic req_ready, ddr_cmd_valid, ck_enable, path_off, m_off;
  logic [3:0] req_cmd = 4'h0, ddr_cmd, m_bad;
  int fails = 0, checked = 0, cyc = 0, t0, t1, tc;
  lp_cmd_gate #(.DLLK_NCK(DLLK)) uut (.core_clk(core_clk), .arst_n(arst_n),
    .req_cmd(req_cmd), .req_valid(req_valid), .sr_abort(sr_abort),
    .parity_en(parity_en), .init_phase(init_phase), .req_ready(req_ready),
    .ddr_cmd(ddr_cmd), .ddr_cmd_valid(ddr_cmd_valid), .ck_enable(ck_enable),
    .dev_cmd_path_off(path_off));
  lp_dev_model dev (.core_clk(core_clk), .arst_n(arst_n), .cmd(ddr_cmd),
    .cmd_valid(ddr_cmd_valid), .ck_enable(ck_enable), .path_off(m_off),
    .bad(m_bad));
  initial forever #50 core_clk = ~core_clk;
  always @(posedge core_clk) cyc++;
  task automatic chk(string n, logic [3:0] e, logic [3:0] g);
    checked++;
    if (e !== g) begin
      fails++;
      $display("[ERR] %s exp %0d got %0d", n, e, g);
    end
  endtask
  task automatic chk_ge(string n, int e, int g);
    checked++;
    if (g < e) begin
      fails++;
      $display("[ERR] %s exp >=%0d got %0d", n, e, g);
    end
  endtask
  task automatic send(logic [3:0] c);
    int n;
    n = 0;
    req_cmd = c;
    req_valid = 1'b1;
    #1;
    while (req_ready !== 1'b1 && n < 3000) begin
      @(negedge core_clk);
      n++;
    end
    @(negedge core_clk);
    req_valid = 1'b0;
    n = 0;
    while (ddr_cmd_valid !== 1'b1 && n < 9) begin
      @(negedge core_clk);
      n++;
    end
    tc = cyc;
    chk("ddr_cmd", c, ddr_cmd);
  endtask
  task automatic wait_ck(logic v);
    int n;
    n = 0;
    while (ck_enable !== v && n < 60) begin
      @(negedge core_clk);
      n++;
    end
    t1 = cyc;
    chk("ck_enable", {3'h0, v}, {3'h0, ck_enable});
  endtask
  task automatic t_zq;
    send(lp_timing_pkg::CMD_ZQ_LONG);
    t0 = tc;
    init_phase = 1'b0;
    send(lp_timing_pkg::CMD_ZQ_LONG);
    chk_ge("zq_init", 1024, tc - t0);
    t0 = tc;
    send(lp_timing_pkg::CMD_ZQ_SHORT);
    chk_ge("zq_oper", 512, tc - t0);
    chk("ready", 4'h0, {3'h0, req_ready});
    t0 = tc;
    send(lp_timing_pkg::CMD_NODLL);
    chk_ge("zq_short", 128, tc - t0);
  endtask
  task automatic t_sr(logic ab, logic pe, logic [3:0] e, c, int mn);
    sr_abort = ab;
    parity_en = pe;
    send(e);
    t0 = tc;
    wait_ck(1'b0);
    chk_ge("ck_hold", pe ? 9 : 5, t1 - t0);
    send(e + 4'h1);
    t0 = tc;
    send(c);
    chk_ge("exit_gap", mn, tc - t0);
  endtask
  task automatic t_mpsm;
    send(lp_timing_pkg::CMD_MPSM_ENTER);
    t0 = tc;
    wait_ck(1'b0);
    chk_ge("ck_mpsm", 28, t1 - t0);
    repeat (2) @(negedge core_clk);
    chk("path_off", 4'h1, {3'h0, path_off});
    chk("dev_off", 4'h1, {3'h0, m_off});
    send(lp_timing_pkg::CMD_MPSM_EXIT);
    t0 = tc;
    send(lp_timing_pkg::CMD_DLL);
    chk_ge("xmpdll", lp_timing_pkg::XMP_NCK_DEF + DLLK, tc - t0);
    chk("dev_bad", 4'h0, m_bad);
  endtask
  task automatic give_verdict;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #1_000_000;
    fails++;
    give_verdict;
  end
  initial begin
    repeat (10) @(negedge core_clk);
    arst_n = 1'b1;
    repeat (3) @(negedge core_clk);
    t_zq;
    t_sr(0, 0, lp_timing_pkg::CMD_SR_ENTER, lp_timing_pkg::CMD_NODLL, XS);
    t_sr(1, 1, lp_timing_pkg::CMD_SR_ENTER, lp_timing_pkg::CMD_NODLL, XS4);
    t_sr(0, 0, lp_timing_pkg::CMD_SR_ENTER, lp_timing_pkg::CMD_MRS_FAST, XS4);
    t_sr(0, 0, lp_timing_pkg::CMD_SR_ENTER, lp_timing_pkg::CMD_DLL, DLLK);
    t_sr(0, 1, lp_timing_pkg::CMD_PD_ENTER, lp_timing_pkg::CMD_NODLL, 0);
    t_mpsm;
    give_verdict;
  end
endmodule
`default_nettype wire
